// File: verilog/pbp_consts.vh
// Register indices, field positions and reset values of the PWM brake and prescaler block
`ifndef PBP_CONSTS_VH
`define PBP_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PBP_IDX_MAIN_CTRL 8'hdc
`define PBP_IDX_BRAKE_CTRL 8'hdf
`define PBP_IDX_FLAG_PRESCALE 8'hd7
`define PBP_IDX_INT_STATUS 8'he0
`define PBP_IDX_INT_MASK 8'he1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PBP_MAIN_RUN_BIT 7
`define PBP_BRK_HALT_SEL_BIT 7
`define PBP_BRK_POL_BIT 6
`define PBP_BRK_PIN_SEL_BIT 5
`define PBP_BRK_EN_BIT 4
`define PBP_BRK_LEVEL_MSB 3
`define PBP_BRK_LEVEL_LSB 0
`define PBP_FP_DIV_MSB 3
`define PBP_FP_DIV_LSB 2
`define PBP_FP_FLAG_BIT 0
`define PBP_INT_BRAKE_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PBP_RST_MAIN_CTRL 8'h00
`define PBP_RST_BRAKE_CTRL 8'h00
`define PBP_RST_FLAG_PRESCALE 8'h00
`define PBP_RST_INT_MASK 8'h00

// ----------------------------------------------------------------
// Prescaler terminal counts (divide minus one)
// ----------------------------------------------------------------
`define PBP_DIV1_LAST 4'h0
`define PBP_DIV2_LAST 4'h1
`define PBP_DIV4_LAST 4'h3
`define PBP_DIV16_LAST 4'hf

`endif

// File: verilog/pbp_top.v
// PWM brake selection, brake output forcing, brake flag, interrupt and clock prescaler
`include "pbp_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module pbp_top #(
    parameter NUM_OUT = 4,
    parameter ADDR_W = 10
) (
    input wire SYS_CLK_I,                 // System clock, 250 MHz
    input wire RST_I,                     // Asynchronous reset, active high
    input wire CE_I,                      // Clock enable, freezes all state when low
    input wire PSEL_I,                    // APB select
    input wire PENABLE_I,                 // APB enable
    input wire PWRITE_I,                  // APB direction, high for write
    input wire [ADDR_W-1:0] PADDR_I,      // APB byte address
    input wire [31:0] PWDATA_I,           // APB write data
    output wire [31:0] PRDATA_O,          // APB read data
    output wire PREADY_O,                 // APB ready
    output wire PSLVERR_O,                // APB error, unmapped address
    input wire BRAKE_INPUT_PIN_I,         // External brake pin, asynchronous
    input wire [NUM_OUT-1:0] PWM_RAW_I,   // Outputs of the compare logic
    output wire [NUM_OUT-1:0] PWM_O,      // PWM outputs after brake forcing
    output wire BRAKE_O,                  // Brake currently asserted
    output wire RUN_O,                    // Counter run bit
    output wire PWM_CLK_EN_O,             // Prescaled PWM clock enable pulse
    output wire IRQ_O                     // Brake interrupt, level
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function [3:0] div_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: div_last = `PBP_DIV1_LAST;
                2'h1: div_last = `PBP_DIV2_LAST;
                2'h2: div_last = `PBP_DIV4_LAST;
                default: div_last = `PBP_DIV16_LAST;
            endcase
        end
    endfunction

    function match_idx;
        input [ADDR_W-1:0] addr;
        input [7:0] idx;
        begin
            match_idx = (addr == {idx, 2'b00});
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg pin_s1_r;
    reg pin_s2_r;
    reg pin_s3_r;
    reg pin_lvl_r;
    reg run_r;
    reg run_nxt;
    reg [7:0] brk_ctrl_r;
    reg [7:0] brk_ctrl_nxt;
    reg flag_r;
    reg flag_nxt;
    reg [1:0] div_sel_r;
    reg [1:0] div_sel_nxt;
    reg int_stat_r;
    reg int_stat_nxt;
    reg int_mask_r;
    reg int_mask_nxt;
    reg pin_brake_d_r;
    reg brake_r;
    reg [NUM_OUT-1:0] pwm_r;
    reg [3:0] pre_cnt_r;
    reg [3:0] pre_cnt_nxt;
    reg clk_en_r;
    reg clk_en_nxt;
    reg irq_r;
    reg pready_r;
    reg pslverr_r;
    reg [31:0] prdata_r;
    reg [31:0] rdata_nxt;
    reg hit_nxt;
    wire access;
    wire wr_fire;
    wire brk_en;
    wire halt_sel;
    wire pin_sel;
    wire pin_active;
    wire pin_brake;
    wire brake_nxt;
    wire [NUM_OUT-1:0] pwm_nxt;
    wire [3:0] last;
    localparam [7:0] RST_MAIN = `PBP_RST_MAIN_CTRL;
    localparam [7:0] RST_FP = `PBP_RST_FLAG_PRESCALE;
    localparam [7:0] RST_MASK = `PBP_RST_INT_MASK;

    // ----------------------------------------------------------------
    // Brake pin synchroniser
    // ----------------------------------------------------------------
    // three flops, level taken when last two agree
    always @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
            pin_lvl_r <= 1'b0;
        end
        else if (CE_I)
        begin
            pin_s1_r <= BRAKE_INPUT_PIN_I;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r)
            begin
                pin_lvl_r <= pin_s3_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Brake condition
    // ----------------------------------------------------------------
    assign brk_en = brk_ctrl_r[`PBP_BRK_EN_BIT];
    assign halt_sel = brk_ctrl_r[`PBP_BRK_HALT_SEL_BIT];
    assign pin_sel = brk_ctrl_r[`PBP_BRK_PIN_SEL_BIT];
    assign pin_active = (pin_lvl_r == brk_ctrl_r[`PBP_BRK_POL_BIT]);
    assign pin_brake = brk_en & pin_sel & ~halt_sel & pin_active;
    // both selects set gives no brake
    assign brake_nxt = brk_en & ((~pin_sel & ~halt_sel) | (~pin_sel & halt_sel & ~run_r) | pin_brake);

    // ----------------------------------------------------------------
    // Output forcing
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1)
        begin : gen_out
            assign pwm_nxt[g] = brake_nxt ? brk_ctrl_r[`PBP_BRK_LEVEL_LSB + g] : PWM_RAW_I[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // APB access
    // ----------------------------------------------------------------
    assign access = PSEL_I & PENABLE_I;
    assign wr_fire = access & pready_r & PWRITE_I;

    // Read mux and address decode
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        hit_nxt = 1'b1;
        if (match_idx(PADDR_I, `PBP_IDX_MAIN_CTRL))
        begin
            rdata_nxt[`PBP_MAIN_RUN_BIT] = run_r;
        end
        else if (match_idx(PADDR_I, `PBP_IDX_BRAKE_CTRL))
        begin
            rdata_nxt[7:0] = brk_ctrl_r;
        end
        else if (match_idx(PADDR_I, `PBP_IDX_FLAG_PRESCALE))
        begin
            rdata_nxt[`PBP_FP_DIV_MSB:`PBP_FP_DIV_LSB] = div_sel_r;
            rdata_nxt[`PBP_FP_FLAG_BIT] = flag_r;
        end
        else if (match_idx(PADDR_I, `PBP_IDX_INT_STATUS))
        begin
            rdata_nxt[`PBP_INT_BRAKE_BIT] = int_stat_r;
        end
        else if (match_idx(PADDR_I, `PBP_IDX_INT_MASK))
        begin
            rdata_nxt[`PBP_INT_BRAKE_BIT] = int_mask_r;
        end
        else
        begin
            hit_nxt = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register next values
    // ----------------------------------------------------------------
    always @*
    begin
        run_nxt = run_r;
        brk_ctrl_nxt = brk_ctrl_r;
        flag_nxt = flag_r;
        div_sel_nxt = div_sel_r;
        int_stat_nxt = int_stat_r;
        int_mask_nxt = int_mask_r;
        if (wr_fire)
        begin
            if (match_idx(PADDR_I, `PBP_IDX_MAIN_CTRL))
            begin
                run_nxt = PWDATA_I[`PBP_MAIN_RUN_BIT];
            end
            else if (match_idx(PADDR_I, `PBP_IDX_BRAKE_CTRL))
            begin
                brk_ctrl_nxt = PWDATA_I[7:0];
            end
            else if (match_idx(PADDR_I, `PBP_IDX_FLAG_PRESCALE))
            begin
                div_sel_nxt = PWDATA_I[`PBP_FP_DIV_MSB:`PBP_FP_DIV_LSB];
                flag_nxt = PWDATA_I[`PBP_FP_FLAG_BIT];
            end
            else if (match_idx(PADDR_I, `PBP_IDX_INT_STATUS))
            begin
                if (PWDATA_I[`PBP_INT_BRAKE_BIT])
                begin
                    int_stat_nxt = 1'b0;
                end
            end
            else if (match_idx(PADDR_I, `PBP_IDX_INT_MASK))
            begin
                int_mask_nxt = PWDATA_I[`PBP_INT_BRAKE_BIT];
            end
        end
        // pin brake clears run, wins over write
        if (pin_brake)
        begin
            run_nxt = 1'b0;
        end
        if (pin_brake)
        begin
            flag_nxt = 1'b1;
        end
        // new pin brake raises interrupt status
        if (pin_brake & ~pin_brake_d_r)
        begin
            int_stat_nxt = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    assign last = div_last(div_sel_r);

    always @*
    begin
        pre_cnt_nxt = 4'h0;
        clk_en_nxt = 1'b0;
        // counter held at zero while halted
        if (run_r)
        begin
            if (pre_cnt_r >= last)
            begin
                clk_en_nxt = 1'b1;
            end
            else
            begin
                pre_cnt_nxt = pre_cnt_r + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            run_r <= RST_MAIN[`PBP_MAIN_RUN_BIT];
            brk_ctrl_r <= `PBP_RST_BRAKE_CTRL;
            flag_r <= RST_FP[`PBP_FP_FLAG_BIT];
            div_sel_r <= RST_FP[`PBP_FP_DIV_MSB:`PBP_FP_DIV_LSB];
            int_stat_r <= 1'b0;
            int_mask_r <= RST_MASK[`PBP_INT_BRAKE_BIT];
            pin_brake_d_r <= 1'b0;
            brake_r <= 1'b0;
            pwm_r <= {NUM_OUT{1'b0}};
            pre_cnt_r <= 4'h0;
            clk_en_r <= 1'b0;
            irq_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (CE_I)
        begin
            run_r <= run_nxt;
            brk_ctrl_r <= brk_ctrl_nxt;
            flag_r <= flag_nxt;
            div_sel_r <= div_sel_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            pin_brake_d_r <= pin_brake;
            brake_r <= brake_nxt;
            pwm_r <= pwm_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            clk_en_r <= clk_en_nxt;
            irq_r <= int_stat_nxt & int_mask_nxt;
            // One wait state, ready for a single cycle
            pready_r <= access & ~pready_r;
            if (access & ~pready_r)
            begin
                pslverr_r <= ~hit_nxt;
                prdata_r <= PWRITE_I ? 32'h0000_0000 : rdata_nxt;
            end
            else
            begin
                pslverr_r <= 1'b0;
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign PWM_O = pwm_r;
    assign BRAKE_O = brake_r;
    assign RUN_O = run_r;
    assign PWM_CLK_EN_O = clk_en_r;
    assign IRQ_O = irq_r;

endmodule

`default_nettype wire

// File: testbench/pbp_brake_src.sv
// Brake pin source with a latch for short pulses
`timescale 1ns/1ns
`default_nettype none
module pbp_brake_src (
    input wire logic clk_i,   // Clock
    input wire logic rst_i,   // Reset
    input wire logic want_i,  // Hold brake active
    input wire logic pol_i,   // Active level
    input wire logic pulse_i, // One-cycle pulse
    input wire logic clr_i,   // Clear latch
    output logic pin_o        // Brake pin
);
    logic held_r;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i || clr_i)
            held_r <= 1'b0;
        else if (pulse_i)
            held_r <= 1'b1;
    end
    assign pin_o = (want_i || pulse_i || held_r) ? pol_i : !pol_i;
endmodule
`default_nettype wire

// File: testbench/pbp_top_asserts.sv
// Port checks of the PWM brake and prescaler block
`timescale 1ns/1ns
`default_nettype none
module pbp_top_asserts #(
    parameter NUM_OUT = 4,
    parameter ADDR_W = 10
) (
    input wire SYS_CLK_I,              // Clock
    input wire RST_I,                  // Reset
    input wire CE_I,                   // Enable
    input wire PSEL_I,                 // Select
    input wire PENABLE_I,              // Access
    input wire PWRITE_I,               // Write
    input wire [ADDR_W-1:0] PADDR_I,   // Address
    input wire [31:0] PWDATA_I,        // Wdata
    input wire [31:0] PRDATA_O,        // Rdata
    input wire PREADY_O,               // Ready
    input wire PSLVERR_O,              // Error
    input wire BRAKE_INPUT_PIN_I,      // Pin
    input wire [NUM_OUT-1:0] PWM_RAW_I, // Raw
    input wire [NUM_OUT-1:0] PWM_O,    // Outputs
    input wire BRAKE_O,                // Brake
    input wire RUN_O,                  // Run
    input wire PWM_CLK_EN_O,           // Tick
    input wire IRQ_O                   // Irq
);
// ----------------------------------------
// Relations
// ----------------------------------------
default clocking cb @(posedge SYS_CLK_I);
endclocking
default disable iff (RST_I);
AST_PWM_PASS: assert property ($past(CE_I) && !BRAKE_O |-> PWM_O == $past(PWM_RAW_I))
    else $error("output not following raw input");
AST_BRAKE_HOLD: assert property (BRAKE_O && $past(BRAKE_O) && !$past(PSEL_I) && !$past(PSEL_I, 2) |-> $stable(PWM_O))
    else $error("output moved during brake");
AST_RUN_DROP: assert property ($fell(RUN_O) |-> BRAKE_O || $past(PSEL_I) || $past(PSEL_I, 2))
    else $error("run fell without cause");
AST_IRQ_CAUSE: assert property ($rose(IRQ_O) |-> BRAKE_O || $past(PSEL_I) || $past(PSEL_I, 2))
    else $error("irq rose without cause");
AST_TICK_IDLE: assert property (!RUN_O && !$past(RUN_O) |-> !PWM_CLK_EN_O)
    else $error("tick while stopped");
AST_TICK_FIRST: assert property ($rose(RUN_O) |-> !PWM_CLK_EN_O)
    else $error("tick at run start");
AST_READY_ONE: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
AST_READY_TIME: assert property (PSEL_I && !PENABLE_I && CE_I ##1 PSEL_I && PENABLE_I && CE_I |=> PREADY_O)
    else $error("ready late");
AST_ERR_READY: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
AST_RDATA_IDLE: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside answer");
COV_ERR: cover property (PSLVERR_O);
COV_BRAKE: cover property ($rose(BRAKE_O));
COV_IRQ: cover property ($rose(IRQ_O));
COV_TICK: cover property (RUN_O && PWM_CLK_EN_O);
endmodule
bind pbp_top pbp_top_asserts #(.NUM_OUT(NUM_OUT), .ADDR_W(ADDR_W)) chk_u (.SYS_CLK_I(SYS_CLK_I),
    .RST_I(RST_I), .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .BRAKE_INPUT_PIN_I(BRAKE_INPUT_PIN_I), .PWM_RAW_I(PWM_RAW_I),
    .PWM_O(PWM_O), .BRAKE_O(BRAKE_O), .RUN_O(RUN_O), .PWM_CLK_EN_O(PWM_CLK_EN_O), .IRQ_O(IRQ_O));
`default_nettype wire

// File: testbench/pbp_top_test.sv
// Self-checking bench of the PWM brake and prescaler block
`timescale 1ns/1ns
`default_nettype none
`include "pbp_consts.vh"
module pbp_top_test;
logic clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0;
logic [9:0] paddr = 0;
logic [31:0] pwdata = 0, rd;
logic [3:0] raw = 0;
logic want = 0, pol = 0, pulse = 0, clr = 0, e;
wire [31:0] prdata;
wire [3:0] pwm;
wire pready, perr, pin, brk, run, tick, irq;
int bad_count = 0, tests_run = 0;
pbp_top dut_u (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(perr), .BRAKE_INPUT_PIN_I(pin), .PWM_RAW_I(raw), .PWM_O(pwm), .BRAKE_O(brk),
    .RUN_O(run), .PWM_CLK_EN_O(tick), .IRQ_O(irq));
pbp_brake_src src_u (.clk_i(clk), .rst_i(rst), .want_i(want), .pol_i(pol), .pulse_i(pulse),
    .clr_i(clr), .pin_o(pin));
initial forever #2 clk = ~clk;
// ----------------------------------------
// Tasks and expectations
// ----------------------------------------
task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
        bad_count++;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do
    begin
        @(posedge clk);
        n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
        bad_count++;
        end_of_test();
    end
    rd = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
endtask
task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic er);
    apb(0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, e}, {31'h0, er});
endtask
function automatic logic exp_brake(input logic [7:0] b, input logic r, input logic act);
    if (!b[4])
        return 1'b0;
    if (!b[7] && !b[5])
        return 1'b1;
    if (b[7])
        return !r;
    return act;
endfunction
function automatic int exp_div(input int f);
    return (f == 3) ? 16 : (1 << f);
endfunction
initial
begin
    logic [7:0] b, m;
    logic r, act, pb, eb;
    int cnt;
    void'($urandom(20152));
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rchk(`PBP_IDX_FLAG_PRESCALE, 32'h0, 0);
    rchk(`PBP_IDX_MAIN_CTRL, 32'h0, 0);
    rchk(`PBP_IDX_BRAKE_CTRL, 32'h0, 0);
    rchk(`PBP_IDX_INT_MASK, 32'h0, 0);
    rchk(8'h00, 32'h0, 1);
    apb(1, `PBP_IDX_FLAG_PRESCALE, 32'hff);
    rchk(`PBP_IDX_FLAG_PRESCALE, 32'h0d, 0);
    for (int f = 0; f < 4; f++)
    begin
        apb(1, `PBP_IDX_FLAG_PRESCALE, {28'h0, f[1:0], 2'b00});
        apb(1, `PBP_IDX_MAIN_CTRL, 32'h80);
        repeat (20) @(posedge clk);
        cnt = 0;
        repeat (64)
        begin
            @(negedge clk);
            cnt += tick;
        end
        chk(cnt, 64 / exp_div(f));
        chk({31'h0, run}, 32'h1);
        @(posedge clk);
        apb(1, `PBP_IDX_MAIN_CTRL, 32'h0);
    end
    apb(1, `PBP_IDX_FLAG_PRESCALE, 32'h0);
    // Clock enable low freezes the output flops
    ce <= 0;
    raw <= 4'h5;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({28'h0, pwm}, 32'h0);
    @(posedge clk);
    ce <= 1;
    @(posedge clk);
    @(negedge clk);
    chk({28'h0, pwm}, 32'h5);
    @(posedge clk);
    for (int i = 0; i < 40; i++)
    begin
        b = $urandom;
        if (b[5])
            b[7] = 1'b0;
        {m, r, act} = $urandom;
        pb = b[4] && b[5] && act;
        eb = exp_brake(b, r, act);
        pol <= b[6];
        raw <= $urandom;
        // Let the new polarity settle through the synchroniser
        repeat (6) @(posedge clk);
        apb(1, `PBP_IDX_BRAKE_CTRL, {24'h0, b});
        apb(1, `PBP_IDX_MAIN_CTRL, {24'h0, r, 7'h0});
        apb(1, `PBP_IDX_INT_MASK, {31'h0, m[0]});
        want <= act && !m[1];
        pulse <= act && m[1];
        @(posedge clk);
        pulse <= 0;
        @(negedge clk);
        chk({31'h0, brk}, {31'h0, exp_brake(b, r, 1'b0)});
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({31'h0, brk}, {31'h0, eb});
        chk({28'h0, pwm}, {28'h0, eb ? b[3:0] : raw});
        chk({31'h0, run}, {31'h0, r && !pb});
        chk({31'h0, irq}, {31'h0, pb && m[0]});
        @(posedge clk);
        rchk(`PBP_IDX_INT_STATUS, {31'h0, pb}, 0);
        want <= 0;
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        apb(1, `PBP_IDX_BRAKE_CTRL, 32'h0);
        rchk(`PBP_IDX_FLAG_PRESCALE, {31'h0, pb}, 0);
        apb(1, `PBP_IDX_FLAG_PRESCALE, 32'h0);
        apb(1, `PBP_IDX_INT_STATUS, 32'h1);
        rchk(`PBP_IDX_FLAG_PRESCALE, 32'h0, 0);
        rchk(`PBP_IDX_INT_STATUS, 32'h0, 0);
        chk({31'h0, irq}, 32'h0);
    end
    end_of_test();
end
endmodule
`default_nettype wire
